// ===== hdl/apf_core.sv
// Active power to frequency converter: optional high-pass and phase match,
// multiply, low-pass, and two accumulators that emit active-low pulses.
// Assumes samples arrive on clk with a one-cycle strobe; pins are asynchronous.

`timescale 1ns/100ps
`default_nettype none

module apf_core (
    input  wire logic                   clk,
    input  wire logic                   rst_b,
    input  wire logic                   hpf_select_input,
    input  wire logic                   supply_above_trip,
    input  wire logic                   sample_strobe,
    input  wire apf_pkg::apf_sample_t   sample,
    output var  logic                   low_rate_pulse_a_n,
    output var  logic                   low_rate_pulse_b_n,
    output var  logic                   calibration_pulse_out_n,
    output var  logic                   supply_good
);

    // =========================================================
    // Accumulate-and-compare, shared by both converters
    function automatic apf_pkg::apf_acc_t acc_step(
        input logic [apf_pkg::ACC_W-1:0]  acc,
        input logic [apf_pkg::PROD_W-1:0] add,
        input logic [apf_pkg::ACC_W-1:0]  thresh
    );
        apf_pkg::apf_acc_t               res;
        logic [apf_pkg::ACC_W-1:0]       sum;
        sum = acc + {{(apf_pkg::ACC_W-apf_pkg::PROD_W){1'b0}}, add};
        if (sum >= thresh) begin
            res.acc  = sum - thresh;
            res.fire = 1'b1;
        end else begin
            res.acc  = sum;
            res.fire = 1'b0;
        end
        return res;
    endfunction

    // =========================================================
    // Pin synchronisers
    logic       sel_meta;
    logic       sel_sync;
    logic       sup_meta;
    logic       sup_sync;

    // Two flops on each asynchronous pin
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sel_meta <= 1'b0;
            sel_sync <= 1'b0;
            sup_meta <= 1'b0;
            sup_sync <= 1'b0;
        end else begin
            sel_meta <= hpf_select_input;
            sel_sync <= sel_meta;
            sup_meta <= supply_above_trip;
            sup_sync <= sup_meta;
        end
    end

    // =========================================================
    // Supply monitor filter with asymmetric hold times
    apf_pkg::apf_supply_t       sup_state;
    apf_pkg::apf_supply_t       next_sup_state;
    logic [apf_pkg::CNT_W-1:0]  sup_cnt;
    logic [apf_pkg::CNT_W-1:0]  next_sup_cnt;
    logic                       next_supply_good;
    logic                       core_clear;

    // State flips only after the opposite level holds long enough
    always_comb begin
        next_sup_state   = sup_state;
        next_sup_cnt     = '0;
        case (sup_state)
            apf_pkg::APF_SUP_DOWN: begin
                if (sup_sync) begin
                    next_sup_cnt = sup_cnt + 1'b1;
                    if (sup_cnt == apf_pkg::CNT_W'(apf_pkg::SUPPLY_RISE_CYC - 1)) begin
                        next_sup_state = apf_pkg::APF_SUP_UP;
                        next_sup_cnt   = '0;
                    end
                end
            end
            apf_pkg::APF_SUP_UP: begin
                if (!sup_sync) begin
                    next_sup_cnt = sup_cnt + 1'b1;
                    if (sup_cnt == apf_pkg::CNT_W'(apf_pkg::SUPPLY_FALL_CYC - 1)) begin
                        next_sup_state = apf_pkg::APF_SUP_DOWN;
                        next_sup_cnt   = '0;
                    end
                end
            end
            default: begin
                next_sup_state = apf_pkg::APF_SUP_DOWN;
            end
        endcase
        next_supply_good = (next_sup_state == apf_pkg::APF_SUP_UP);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sup_state   <= apf_pkg::APF_SUP_DOWN;
            sup_cnt     <= '0;
            supply_good <= 1'b0;
        end else begin
            sup_state   <= next_sup_state;
            sup_cnt     <= next_sup_cnt;
            supply_good <= next_supply_good;
        end
    end

    assign core_clear = !supply_good;

    // =========================================================
    // High-pass stage; the voltage channel runs an identical filter
    // so both paths carry the same phase at every frequency
    logic signed [apf_pkg::SAMPLE_W-1:0]    cur_f;
    logic signed [apf_pkg::SAMPLE_W-1:0]    volt_f;
    logic                                   s1_valid;

    apf_hpf u_hpf_current (
        .clk    (clk),
        .clear  (core_clear),
        .rst_b  (rst_b),
        .enable (sel_sync),
        .strobe (sample_strobe),
        .din    (sample.current),
        .dout   (cur_f)
    );

    apf_hpf u_hpf_voltage (
        .clk    (clk),
        .clear  (core_clear),
        .rst_b  (rst_b),
        .enable (sel_sync),
        .strobe (sample_strobe),
        .din    (sample.voltage),
        .dout   (volt_f)
    );

    // =========================================================
    // Multiply and low-pass
    logic                                   p_valid;
    logic                                   next_p_valid;
    logic signed [apf_pkg::PROD_W-1:0]      prod;
    logic signed [apf_pkg::PROD_W-1:0]      next_prod;
    logic signed [apf_pkg::PROD_W-1:0]      lpf;
    logic signed [apf_pkg::PROD_W-1:0]      next_lpf;
    logic                                   l_valid;
    logic                                   next_l_valid;
    logic                                   next_s1_valid;
    logic signed [apf_pkg::PROD_W:0]        lpf_err;

    always_comb begin
        next_s1_valid = sample_strobe && !core_clear;
        next_p_valid  = s1_valid && !core_clear;
        next_l_valid  = p_valid && !core_clear;
        next_prod     = prod;
        next_lpf      = lpf;
        lpf_err       = (apf_pkg::PROD_W+1)'(prod) - (apf_pkg::PROD_W+1)'(lpf);
        if (core_clear) begin
            next_prod = '0;
            next_lpf  = '0;
        end else begin
            if (s1_valid) begin
                next_prod = cur_f * volt_f;
            end
            if (p_valid) begin
                // First-order pole near 8.9 Hz at the sample rate
                next_lpf = lpf + apf_pkg::PROD_W'(lpf_err >>> apf_pkg::LPF_SHIFT);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_valid <= 1'b0;
            p_valid  <= 1'b0;
            l_valid  <= 1'b0;
            prod     <= '0;
            lpf      <= '0;
        end else begin
            s1_valid <= next_s1_valid;
            p_valid  <= next_p_valid;
            l_valid  <= next_l_valid;
            prod     <= next_prod;
            lpf      <= next_lpf;
        end
    end

    // =========================================================
    // Digital to frequency conversion
    logic [apf_pkg::ACC_W-1:0]      low_acc;
    logic [apf_pkg::ACC_W-1:0]      next_low_acc;
    logic [apf_pkg::ACC_W-1:0]      cal_acc;
    logic [apf_pkg::ACC_W-1:0]      next_cal_acc;
    logic                           low_fire;
    logic                           cal_fire;
    logic [apf_pkg::PROD_W-1:0]     pos_power;
    apf_pkg::apf_acc_t              low_step;
    apf_pkg::apf_acc_t              cal_step;

    // Only positive active power drives the counters
    always_comb begin
        pos_power    = lpf[apf_pkg::PROD_W-1] ? '0 : lpf;
        low_step     = acc_step(low_acc, pos_power, apf_pkg::LOW_THRESH);
        cal_step     = acc_step(cal_acc, pos_power, apf_pkg::CAL_THRESH);
        next_low_acc = low_acc;
        next_cal_acc = cal_acc;
        low_fire     = 1'b0;
        cal_fire     = 1'b0;
        if (core_clear) begin
            next_low_acc = apf_pkg::ACC_RESET;
            next_cal_acc = apf_pkg::ACC_RESET;
        end else if (l_valid) begin
            next_low_acc = low_step.acc;
            next_cal_acc = cal_step.acc;
            low_fire     = low_step.fire;
            cal_fire     = cal_step.fire;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            low_acc <= apf_pkg::ACC_RESET;
            cal_acc <= apf_pkg::ACC_RESET;
        end else begin
            low_acc <= next_low_acc;
            cal_acc <= next_cal_acc;
        end
    end

    // =========================================================
    // Pulse stretchers; a new quantum restarts the width
    logic [apf_pkg::CNT_W-1:0]      low_cnt;
    logic [apf_pkg::CNT_W-1:0]      next_low_cnt;
    logic [apf_pkg::CNT_W-1:0]      cal_cnt;
    logic [apf_pkg::CNT_W-1:0]      next_cal_cnt;
    logic                           next_low_n;
    logic                           next_cal_n;

    always_comb begin
        next_low_cnt = (low_cnt != '0) ? low_cnt - 1'b1 : low_cnt;
        next_cal_cnt = (cal_cnt != '0) ? cal_cnt - 1'b1 : cal_cnt;
        if (low_fire) begin
            next_low_cnt = apf_pkg::CNT_W'(apf_pkg::LOW_PULSE_CYC);
        end
        if (cal_fire) begin
            next_cal_cnt = apf_pkg::CNT_W'(apf_pkg::CAL_PULSE_CYC);
        end
        if (core_clear) begin
            next_low_cnt = '0;
            next_cal_cnt = '0;
        end
        next_low_n = (next_low_cnt == '0);
        next_cal_n = (next_cal_cnt == '0);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            low_cnt                 <= '0;
            cal_cnt                 <= '0;
            low_rate_pulse_a_n      <= 1'b1;
            low_rate_pulse_b_n      <= 1'b1;
            calibration_pulse_out_n <= 1'b1;
        end else begin
            low_cnt                 <= next_low_cnt;
            cal_cnt                 <= next_cal_cnt;
            low_rate_pulse_a_n      <= next_low_n;
            low_rate_pulse_b_n      <= next_low_n;
            calibration_pulse_out_n <= next_cal_n;
        end
    end

endmodule

`default_nettype wire

// ===== hdl/apf_pkg.sv
// Package for the active power to frequency back end.
// Holds sample carrier types, filter shifts, thresholds and timing counts.
// Assumes a 10 MHz system clock and one sample strobe per converter output.

package apf_pkg;

    // =========================================================
    // Clock and timing
    localparam int  CLK_HZ             = 10_000_000;
    localparam int  SUPPLY_RISE_US     = 100;   // Good level must hold this long
    localparam int  SUPPLY_FALL_US     = 10;    // Bad level must hold this long
    localparam int  LOW_PULSE_US       = 200;   // Low-rate pulse width
    localparam int  CAL_PULSE_US       = 20;    // Calibration pulse width
    localparam int  SUPPLY_RISE_CYC    = (SUPPLY_RISE_US * (CLK_HZ / 1_000_000) > 1) ?
                                         SUPPLY_RISE_US * (CLK_HZ / 1_000_000) : 1;
    localparam int  SUPPLY_FALL_CYC    = (SUPPLY_FALL_US * (CLK_HZ / 1_000_000) > 1) ?
                                         SUPPLY_FALL_US * (CLK_HZ / 1_000_000) : 1;
    localparam int  LOW_PULSE_CYC      = LOW_PULSE_US * (CLK_HZ / 1_000_000);
    localparam int  CAL_PULSE_CYC      = CAL_PULSE_US * (CLK_HZ / 1_000_000);
    localparam int  CNT_W              = 12;

    // =========================================================
    // Filters
    localparam int  SAMPLE_W           = 16;
    localparam int  HPF_FRAC           = 8;     // Fraction bits in the high-pass state
    localparam int  HPF_SHIFT          = 10;    // Pole coefficient 1 - 2^-10
    localparam int  HPF_W              = 32;
    localparam int  PROD_W             = 32;
    localparam int  LPF_CORNER_MHZ     = 8_900; // 8.9 Hz corner, in millihertz
    localparam int  LPF_SHIFT          = 9;     // 2^-9 step at a ~28 kHz sample rate

    // =========================================================
    // Digital to frequency conversion
    localparam int  ACC_W              = 48;
    localparam int  CAL_RATIO_LOG2     = 11;    // Calibration runs 2048 times faster
    localparam logic [ACC_W-1:0] LOW_THRESH = 48'h0080_0000_0000;
    localparam logic [ACC_W-1:0] CAL_THRESH = LOW_THRESH >> CAL_RATIO_LOG2;
    localparam logic [ACC_W-1:0] ACC_RESET  = 48'h0000_0000_0000;

    // =========================================================
    // Carriers
    typedef struct packed {
        logic signed [SAMPLE_W-1:0] current;
        logic signed [SAMPLE_W-1:0] voltage;
    } apf_sample_t;

    typedef struct packed {
        logic [ACC_W-1:0] acc;
        logic             fire;
    } apf_acc_t;

    typedef enum logic [1:0] {
        APF_SUP_DOWN,
        APF_SUP_UP
    } apf_supply_t;

endpackage

// ===== hdl/apf_hpf.sv
// First-order dc blocking filter with a bypass path.
// Assumes din is valid on strobe and clear is synchronous to clk.

`timescale 1ns/100ps
`default_nettype none

module apf_hpf (
    input  wire logic                                   clk,
    input  wire logic                                   rst_b,
    input  wire logic                                   clear,
    input  wire logic                                   enable,
    input  wire logic                                   strobe,
    input  wire logic signed [apf_pkg::SAMPLE_W-1:0]    din,
    output var  logic signed [apf_pkg::SAMPLE_W-1:0]    dout
);

    logic signed [apf_pkg::HPF_W-1:0]       state;
    logic signed [apf_pkg::HPF_W-1:0]       next_state;
    logic signed [apf_pkg::SAMPLE_W-1:0]    prev;
    logic signed [apf_pkg::SAMPLE_W-1:0]    next_prev;
    logic signed [apf_pkg::SAMPLE_W-1:0]    next_dout;
    logic signed [apf_pkg::HPF_W-1:0]       diff;

    // =========================================================
    // Filter update: y += (x - x_prev) - y * 2^-k
    always_comb begin
        diff       = (apf_pkg::HPF_W'(din) - apf_pkg::HPF_W'(prev)) <<< apf_pkg::HPF_FRAC;
        next_state = state;
        next_prev  = prev;
        next_dout  = dout;
        if (clear) begin
            next_state = '0;
            next_prev  = '0;
            next_dout  = '0;
        end else if (strobe) begin
            next_state = state + diff - (state >>> apf_pkg::HPF_SHIFT);
            next_prev  = din;
            // Bypass keeps the same one-sample latency
            next_dout  = enable ? state[apf_pkg::HPF_FRAC +: apf_pkg::SAMPLE_W] : prev;
        end
    end

    // Filter registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= '0;
            prev  <= '0;
            dout  <= '0;
        end else begin
            state <= next_state;
            prev  <= next_prev;
            dout  <= next_dout;
        end
    end

endmodule

`default_nettype wire

// ===== verif/apf_core_checker.sv
// Checker for the power to frequency core, bound to apf_core.
// Assumes it sees only the core's ports on the single clock.
`timescale 1ns/100ps
`default_nettype none

module apf_core_checker (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic supply_above_trip,
    input wire logic sample_strobe,
    input wire logic low_rate_pulse_a_n,
    input wire logic low_rate_pulse_b_n,
    input wire logic calibration_pulse_out_n,
    input wire logic supply_good
);
    logic [11:0] low_run, cal_run, sup_hi, sup_lo;
    logic [11:0] next_low_run, next_cal_run, next_sup_hi, next_sup_lo;

    // =========================================================
    // Run lengths of low outputs and of the raw supply level
    function automatic logic [11:0] step(input logic keep, input logic [11:0] run);
        return keep ? ((run == 12'hFFF) ? run : run + 12'h001) : 12'h000;
    endfunction

    // Next run lengths
    always_comb begin
        next_low_run = step(!low_rate_pulse_a_n, low_run);
        next_cal_run = step(!calibration_pulse_out_n, cal_run);
        next_sup_hi  = step(supply_above_trip, sup_hi);
        next_sup_lo  = step(!supply_above_trip, sup_lo);
    end

    // Run length registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            {low_run, cal_run, sup_hi, sup_lo} <= 48'h0000_0000_0000;
        end else begin
            {low_run, cal_run, sup_hi, sup_lo} <= {next_low_run, next_cal_run, next_sup_hi, next_sup_lo};
        end
    end

    // =========================================================
    // Assertions
    pulse_pair_a: assert property (@(posedge clk) disable iff (!rst_b)
        low_rate_pulse_a_n == low_rate_pulse_b_n) else $error("low-rate outputs differ");
    reset_quiet_a: assert property (@(posedge clk) disable iff (!rst_b)
        !supply_good |=> low_rate_pulse_a_n && low_rate_pulse_b_n && calibration_pulse_out_n)
        else $error("pulse output low while supply is bad");
    low_width_a: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(low_rate_pulse_a_n) && supply_good && $past(supply_good) |-> low_run >= apf_pkg::LOW_PULSE_CYC)
        else $error("low-rate pulse too short");
    cal_width_a: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(calibration_pulse_out_n) && supply_good && $past(supply_good) |-> cal_run >= apf_pkg::CAL_PULSE_CYC)
        else $error("calibration pulse too short");
    low_cause_a: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(low_rate_pulse_a_n) |-> $past(sample_strobe, 4) && $past(supply_good, 4))
        else $error("low-rate pulse without a taken sample");
    cal_cause_a: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(calibration_pulse_out_n) |-> $past(sample_strobe, 4) && $past(supply_good, 4))
        else $error("calibration pulse without a taken sample");
    supply_rise_a: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(supply_good) |-> sup_hi >= apf_pkg::SUPPLY_RISE_CYC) else $error("supply good too early");
    supply_fall_a: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(supply_good) |-> sup_lo >= apf_pkg::SUPPLY_FALL_CYC) else $error("supply drop too early");
    rise_bound_a: assert property (@(posedge clk) disable iff (!rst_b)
        sup_hi >= 12'h3F2 |-> supply_good) else $error("supply good late");
    fall_bound_a: assert property (@(posedge clk) disable iff (!rst_b)
        sup_lo >= 12'h06E |-> !supply_good) else $error("supply drop late");
endmodule

bind apf_core apf_core_checker checker_inst (
    .clk(clk), .rst_b(rst_b), .supply_above_trip(supply_above_trip), .sample_strobe(sample_strobe),
    .low_rate_pulse_a_n(low_rate_pulse_a_n), .low_rate_pulse_b_n(low_rate_pulse_b_n),
    .calibration_pulse_out_n(calibration_pulse_out_n), .supply_good(supply_good));
`default_nettype wire

// ===== verif/apf_pulse_counter.sv
// Counting party on one active-low pulse output.
// Assumes a synchronous clear that opens each measurement window.
`timescale 1ns/100ps
`default_nettype none

module apf_pulse_counter (
    input  wire logic        clk,
    input  wire logic        clear,
    input  wire logic        pulse_n,
    output var  logic [15:0] pulses,
    output var  logic [15:0] min_width,
    output var  logic [15:0] max_width
);
    logic [15:0] run;
    logic        prev_n;
    logic        seen;

    // =========================================================
    // Tallies over a window: counts falls, keeps min and max widths of whole pulses
    always_ff @(posedge clk) begin
        prev_n <= pulse_n;
        if (clear) begin
            pulses    <= 16'h0000;
            min_width <= 16'hFFFF;
            max_width <= 16'h0000;
            seen      <= 1'b0;
            run       <= 16'h0000;
        end else if (!pulse_n) begin
            run    <= run + 16'h0001;
            seen   <= seen || prev_n;
            pulses <= pulses + {15'h0000, prev_n};
        end else begin
            run <= 16'h0000;
            if (seen && !prev_n) begin
                min_width <= (run < min_width) ? run : min_width;
                max_width <= (run > max_width) ? run : max_width;
            end
        end
    end
endmodule
`default_nettype wire

// ===== verif/tb.sv
// Self-checking bench for the power to frequency core.
// Assumes the core, its package, the checker and the pulse counter are compiled.
`timescale 1ns/100ps
`default_nettype none

module tb;
    logic                 clk = 1'b0;
    logic                 rst_b = 1'b0;
    logic                 hpf_select_input = 1'b0;
    logic                 supply_above_trip = 1'b1;
    logic                 sample_strobe = 1'b0;
    apf_pkg::apf_sample_t sample = 32'h0000_0000;
    logic                 clear = 1'b1;
    logic                 low_a_n, low_b_n, cal_n, supply_good;
    logic [15:0]          a_cnt, b_cnt, c_cnt, a_min, a_max, c_min, c_max;
    int                   miscompares = 0;
    int                   checks = 0;

    // =========================================================
    // Clock, design and counting party
    always #50 clk = ~clk;

    apf_core apf_core_inst (.clk(clk), .rst_b(rst_b), .hpf_select_input(hpf_select_input),
        .supply_above_trip(supply_above_trip), .sample_strobe(sample_strobe), .sample(sample),
        .low_rate_pulse_a_n(low_a_n), .low_rate_pulse_b_n(low_b_n),
        .calibration_pulse_out_n(cal_n), .supply_good(supply_good));
    apf_pulse_counter cnt_a (.clk(clk), .clear(clear), .pulse_n(low_a_n), .pulses(a_cnt),
        .min_width(a_min), .max_width(a_max));
    apf_pulse_counter cnt_b (.clk(clk), .clear(clear), .pulse_n(low_b_n), .pulses(b_cnt),
        .min_width(), .max_width());
    apf_pulse_counter cnt_c (.clk(clk), .clear(clear), .pulse_n(cal_n), .pulses(c_cnt),
        .min_width(c_min), .max_width(c_max));

    // =========================================================
    // Shared tasks
    task automatic test_done();
        if (miscompares == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic check_in(input string what, input longint lo, input longint hi, input logic [63:0] got);
        checks++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            miscompares++;
            $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask

    task automatic wait_supply(input logic level, input int bound);
        int k;
        k = 0;
        while (supply_good !== level && k < bound) begin
            @(posedge clk);
            k++;
        end
        check("supply_good", 64'(level), 64'(supply_good));
        if (supply_good !== level) begin
            test_done();
        end
    endtask

    // One strobe every four cycles with a fixed sample pair
    task automatic feed(input int n, input logic [15:0] cur, input logic [15:0] vol);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            sample_strobe <= 1'b1;
            sample        <= {cur, vol};
            @(posedge clk);
            sample_strobe <= 1'b0;
            repeat (2) @(posedge clk);
        end
        repeat (10) @(posedge clk);
    endtask

    task automatic window();
        @(posedge clk);
        clear <= 1'b1;
        @(posedge clk);
        clear <= 1'b0;
    endtask

    task automatic power_cycle();
        @(posedge clk);
        supply_above_trip <= 1'b0;
        wait_supply(1'b0, 150);
        repeat (5) @(posedge clk);
        check("outputs in reset", 64'h7, 64'({low_a_n, low_b_n, cal_n}));
        supply_above_trip <= 1'b1;
        wait_supply(1'b1, 1100);
    endtask

    // =========================================================
    // Scenarios
    task automatic t_reset();
        repeat (900) @(posedge clk);
        check("supply_good early", 64'h0, 64'(supply_good));
        check("outputs after reset", 64'h7, 64'({low_a_n, low_b_n, cal_n}));
        wait_supply(1'b1, 200);
    endtask

    task automatic t_zero();
        window();
        feed(600, 16'h7FFF, 16'h0000);
        check("pulses at zero voltage", 64'h0, 64'({a_cnt, c_cnt}));
    endtask

    task automatic t_big();
        longint p;
        p = longint'(32767) * 32767;
        window();
        feed(8, 16'h7FFF, 16'h7FFF);
        check("calibration during filter rise", 64'h0, 64'(c_cnt));
        feed(5992, 16'h7FFF, 16'h7FFF);
        check("pulse count b", 64'(a_cnt), 64'(b_cnt));
        check_in("pulse count a", (4976 * p) / (2.0 ** 39), (6000 * p) / (2.0 ** 39) + 1, 64'(a_cnt));
        check("low pulse min width", 64'(apf_pkg::LOW_PULSE_CYC), 64'(a_min));
        check("low pulse max width", 64'(apf_pkg::LOW_PULSE_CYC), 64'(a_max));
    endtask

    task automatic t_supply();
        @(posedge clk);
        supply_above_trip <= 1'b0;
        repeat (50) @(posedge clk);
        supply_above_trip <= 1'b1;
        repeat (10) @(posedge clk);
        check("supply_good after glitch", 64'h1, 64'(supply_good));
        power_cycle();
    endtask

    task automatic t_neg();
        window();
        feed(600, 16'h8001, 16'h7FFF);
        check("pulses at negative power", 64'h0, 64'({a_cnt, c_cnt}));
    endtask

    task automatic t_cal();
        window();
        feed(4096, 16'h0800, 16'h0800);
        check_in("calibration count", 48, 65, 64'(c_cnt));
        check("low-rate count", 64'h0, 64'(a_cnt));
        check("calibration min width", 64'(apf_pkg::CAL_PULSE_CYC), 64'(c_min));
        check("calibration max width", 64'(apf_pkg::CAL_PULSE_CYC), 64'(c_max));
    endtask

    task automatic t_hpf();
        hpf_select_input <= 1'b1;
        power_cycle();
        window();
        feed(4096, 16'h0800, 16'h0800);
        check_in("calibration count with dc removed", 0, 18, 64'(c_cnt));
    endtask

    // =========================================================
    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_zero();
        t_big();
        t_supply();
        t_neg();
        power_cycle();
        t_cal();
        t_hpf();
        test_done();
    end
endmodule
`default_nettype wire
